/* pgnco_map.svh */
`ifndef PGNCO_MAP_SVH
`define PGNCO_MAP_SVH

`define PGNCO_OFS_THR_LOW       8'h29
`define PGNCO_OFS_THR_HIGH      8'h2A
`define PGNCO_OFS_GUARD_CTRL    8'h2B
`define PGNCO_OFS_PWR_LOW       8'h2C
`define PGNCO_OFS_PWR_HIGH      8'h2D
`define PGNCO_OFS_OSC_CTRL      8'h30
`define PGNCO_OFS_TUNE0         8'h31
`define PGNCO_OFS_TUNE1         8'h32
`define PGNCO_OFS_TUNE2         8'h33
`define PGNCO_OFS_TUNE3         8'h34

`define PGNCO_RST_BYTE          8'h00
`define PGNCO_RST_TUNE3         8'h10

`define PGNCO_BIT_PROT_EN       7
`define PGNCO_BIT_EXCHANGE      6
`define PGNCO_WIN_MSB           3
`define PGNCO_HIGH5_MSB         4
`define PGNCO_BIT_HOST_ASK      0
`define PGNCO_BIT_HOST_DONE     1
`define PGNCO_BIT_PHASE_ASK     4
`define PGNCO_BIT_PHASE_DONE    5
`define PGNCO_BIT_FRAME_STAT    6

`define PGNCO_WIN_BASE_LOG2     5'h09
`define PGNCO_WIN_MAX_CODE      4'hA
`define PGNCO_PWR_LSB           19
`endif

/* pgnco_pkg.sv */
package pgnco_pkg;
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } pgnco_iq_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pgnco_reg_req_type;

    typedef enum logic [2:0] {
        PGNCO_HS_IDLE = 3'b001,
        PGNCO_HS_ACT  = 3'b010,
        PGNCO_HS_HOLD = 3'b100
    } pgnco_hs_state_type;
endpackage

/* pgnco_handshake.sv */
`include "pgnco_map.svh"
module pgnco_handshake
    import pgnco_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ask,
    output logic      fire_ff,
    output logic      done_ff
);
    pgnco_hs_state_type state_ff;
    pgnco_hs_state_type nxt_state;

    // Four-phase sequence: act once, raise done, wait for the ask to drop, drop done.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PGNCO_HS_IDLE: if (ask) nxt_state = PGNCO_HS_ACT;
            PGNCO_HS_ACT:  nxt_state = PGNCO_HS_HOLD;
            PGNCO_HS_HOLD: if (!ask) nxt_state = PGNCO_HS_IDLE;
            default:       nxt_state = PGNCO_HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= PGNCO_HS_IDLE;
            fire_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            fire_ff  <= (nxt_state == PGNCO_HS_ACT);
            done_ff  <= (nxt_state == PGNCO_HS_HOLD);
        end
    end
endmodule // pgnco_handshake

/* pgnco_power_avg.sv */
`include "pgnco_map.svh"
module pgnco_power_avg
    import pgnco_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         smp_valid,
    input  pgnco_iq_type      smp,
    input  wire logic         exchange,
    input  wire logic [3:0]   win_code,
    output logic [12:0]       avg_ff,
    output logic              win_end_ff
);
    logic [50:0] acc_ff;
    logic [19:0] cnt_ff;

    function automatic logic [30:0] square(input logic signed [15:0] v);
        logic signed [31:0] p;
        p = v * v;
        return p[30:0];
    endfunction

    // Codes above the last valid one are clamped so the window stays finite.
    wire logic [3:0]  code_eff = (win_code > `PGNCO_WIN_MAX_CODE) ? `PGNCO_WIN_MAX_CODE : win_code;
    wire logic [4:0]  shift    = `PGNCO_WIN_BASE_LOG2 + {1'b0, code_eff};
    wire logic [19:0] last_idx = 20'((21'h000001 << shift) - 21'h000001);
    wire logic signed [15:0] a_smp = exchange ? smp.q : smp.i;
    wire logic signed [15:0] b_smp = exchange ? smp.i : smp.q;
    wire logic [31:0] pwr      = {1'b0, square(a_smp)} + {1'b0, square(b_smp)};
    wire logic [50:0] acc_sum  = acc_ff + {19'h00000, pwr};
    wire logic        at_end   = smp_valid && (cnt_ff >= last_idx);
    wire logic [50:0] avg_full = acc_sum >> shift;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_ff     <= 51'h0;
            cnt_ff     <= 20'h00000;
            avg_ff     <= 13'h0000;
            win_end_ff <= 1'b0;
        end else begin
            win_end_ff <= at_end;
            if (at_end) begin
                acc_ff <= 51'h0;
                cnt_ff <= 20'h00000;
                avg_ff <= avg_full[31:`PGNCO_PWR_LSB];
            end else if (smp_valid) begin
                acc_ff <= acc_sum;
                cnt_ff <= cnt_ff + 20'h00001;
            end
        end
    end
endmodule // pgnco_power_avg

/* pgnco_regs.sv */
`include "pgnco_map.svh"
module pgnco_regs
    import pgnco_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  pgnco_reg_req_type  reg_req,
    output logic [7:0]         reg_rdata_ff,
    output logic               reg_rvalid_ff,
    input  wire logic          smp_valid,
    input  pgnco_iq_type       smp,
    input  wire logic          frame_retune,
    output logic               protect_trip_ff,
    output logic signed [31:0] tuning_word_ff,
    output logic               phase_clear_ff
);
    logic [7:0]  thr_low_ff;
    logic [7:0]  thr_high_ff;
    logic [7:0]  guard_ctrl_ff;
    logic        host_retune_ask_ff;
    logic        phase_clear_ask_ff;
    logic        frame_retune_status_ff;
    logic [7:0]  tune_ff [4];
    logic [12:0] power_avg;
    logic        win_end;
    logic        host_fire;
    logic        host_retune_done;
    logic        phase_fire;
    logic        phase_clear_done;

    wire logic sel_thr_low  = (reg_req.addr == `PGNCO_OFS_THR_LOW);
    wire logic sel_thr_high = (reg_req.addr == `PGNCO_OFS_THR_HIGH);
    wire logic sel_guard    = (reg_req.addr == `PGNCO_OFS_GUARD_CTRL);
    wire logic sel_pwr_low  = (reg_req.addr == `PGNCO_OFS_PWR_LOW);
    wire logic sel_pwr_high = (reg_req.addr == `PGNCO_OFS_PWR_HIGH);
    wire logic sel_osc      = (reg_req.addr == `PGNCO_OFS_OSC_CTRL);
    wire logic sel_tune     = (reg_req.addr >= `PGNCO_OFS_TUNE0) && (reg_req.addr <= `PGNCO_OFS_TUNE3);
    wire logic [1:0] tune_idx = 2'(reg_req.addr - `PGNCO_OFS_TUNE0);

    wire logic        wr_osc     = reg_req.wr && sel_osc;
    wire logic [12:0] threshold  = {thr_high_ff[`PGNCO_HIGH5_MSB:0], thr_low_ff};
    wire logic        prot_on    = guard_ctrl_ff[`PGNCO_BIT_PROT_EN];
    wire logic        over       = (power_avg >= threshold);
    wire logic [31:0] shadow_word = {tune_ff[3], tune_ff[2], tune_ff[1], tune_ff[0]};
    wire logic        apply_word = host_fire || frame_retune;

    wire logic [7:0] osc_view = {1'b0,
                                 frame_retune_status_ff,
                                 phase_clear_done,
                                 phase_clear_ask_ff,
                                 2'b00,
                                 host_retune_done,
                                 host_retune_ask_ff};

    logic [7:0] rd_mux;
    always_comb begin
        if (sel_thr_low) begin
            rd_mux = thr_low_ff;
        end else if (sel_thr_high) begin
            rd_mux = {3'b000, thr_high_ff[`PGNCO_HIGH5_MSB:0]};
        end else if (sel_guard) begin
            rd_mux = {guard_ctrl_ff[7:6], 2'b00, guard_ctrl_ff[`PGNCO_WIN_MSB:0]};
        end else if (sel_pwr_low) begin
            rd_mux = power_avg[7:0];
        end else if (sel_pwr_high) begin
            rd_mux = {3'b000, power_avg[12:8]};
        end else if (sel_osc) begin
            rd_mux = osc_view;
        end else if (sel_tune) begin
            rd_mux = tune_ff[tune_idx];
        end else begin
            rd_mux = 8'h00;
        end
    end

    pgnco_power_avg u_power_avg (
        .clk        (clk),
        .arst_n     (arst_n),
        .smp_valid  (smp_valid),
        .smp        (smp),
        .exchange   (guard_ctrl_ff[`PGNCO_BIT_EXCHANGE]),
        .win_code   (guard_ctrl_ff[`PGNCO_WIN_MSB:0]),
        .avg_ff     (power_avg),
        .win_end_ff (win_end)
    );

    pgnco_handshake u_host_retune (
        .clk     (clk),
        .arst_n  (arst_n),
        .ask     (host_retune_ask_ff),
        .fire_ff (host_fire),
        .done_ff (host_retune_done)
    );

    pgnco_handshake u_phase_clear (
        .clk     (clk),
        .arst_n  (arst_n),
        .ask     (phase_clear_ask_ff),
        .fire_ff (phase_fire),
        .done_ff (phase_clear_done)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            thr_low_ff    <= `PGNCO_RST_BYTE;
            thr_high_ff   <= `PGNCO_RST_BYTE;
            guard_ctrl_ff <= `PGNCO_RST_BYTE;
        end else if (reg_req.wr) begin
            if (sel_thr_low) begin
                thr_low_ff <= reg_req.wdata;
            end else if (sel_thr_high) begin
                thr_high_ff <= reg_req.wdata;
            end else if (sel_guard) begin
                guard_ctrl_ff <= reg_req.wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_retune_ask_ff <= 1'b0;
            phase_clear_ask_ff <= 1'b0;
        end else if (wr_osc) begin
            host_retune_ask_ff <= reg_req.wdata[`PGNCO_BIT_HOST_ASK];
            phase_clear_ask_ff <= reg_req.wdata[`PGNCO_BIT_PHASE_ASK];
        end
    end

    // A frame update in the same cycle as a control write keeps the status set.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_retune_status_ff <= 1'b0;
        end else if (frame_retune) begin
            frame_retune_status_ff <= 1'b1;
        end else if (wr_osc) begin
            frame_retune_status_ff <= 1'b0;
        end
    end

    // Byte writes land only in the shadow copy; the active word moves on an update alone.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tune_ff[0] <= `PGNCO_RST_BYTE;
            tune_ff[1] <= `PGNCO_RST_BYTE;
            tune_ff[2] <= `PGNCO_RST_BYTE;
            tune_ff[3] <= `PGNCO_RST_TUNE3;
        end else if (reg_req.wr && sel_tune) begin
            tune_ff[tune_idx] <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tuning_word_ff <= 32'sh00000000;
        end else if (apply_word) begin
            tuning_word_ff <= signed'(shadow_word);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_clear_ff <= 1'b0;
        end else begin
            phase_clear_ff <= phase_fire;
        end
    end

    // The trip follows the latest window; turning protection off clears it at once.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            protect_trip_ff <= 1'b0;
        end else if (!prot_on) begin
            protect_trip_ff <= 1'b0;
        end else if (win_end) begin
            protect_trip_ff <= over;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_ff  <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_req.rd;
            reg_rdata_ff  <= reg_req.rd ? rd_mux : 8'h00;
        end
    end
endmodule // pgnco_regs

/* pgnco_regs_assertions.sv */
module pgnco_regs_checker
    import pgnco_pkg::*;
(
    input wire logic                clk,
    input wire logic                arst_n,
    input pgnco_reg_req_type        reg_req,
    input wire logic [7:0]          reg_rdata_ff,
    input wire logic                reg_rvalid_ff,
    input wire logic                smp_valid,
    input pgnco_iq_type             smp,
    input wire logic                frame_retune,
    input wire logic                protect_trip_ff,
    input wire logic signed [31:0]  tuning_word_ff,
    input wire logic                phase_clear_ff
);
    wire osc_wr    = reg_req.wr && reg_req.addr == 8'h30;
    wire tune_ask  = osc_wr && reg_req.wdata[0];
    wire phase_ask = osc_wr && reg_req.wdata[4];
    wire guard_off = reg_req.wr && reg_req.addr == 8'h2B && !reg_req.wdata[7];
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_read_answer_next: assert property (reg_req.rd |=> reg_rvalid_ff)
        else $error("read strobe got no answer in the next cycle");
    a_answer_needs_read: assert property (reg_rvalid_ff |-> $past(reg_req.rd))
        else $error("read answer without a read strobe");
    a_idle_data_zero: assert property (!reg_rvalid_ff |-> reg_rdata_ff == 8'h00)
        else $error("read data not zero outside an answer");
    a_osc_reserved_zero: assert property (reg_rvalid_ff && $past(reg_req.addr == 8'h30)
        |-> reg_rdata_ff[7] == 1'b0 && reg_rdata_ff[3:2] == 2'b00)
        else $error("oscillator control reserved bits read nonzero");
    a_power_high_width: assert property (reg_rvalid_ff && $past(reg_req.addr == 8'h2D)
        |-> reg_rdata_ff[7:5] == 3'h0)
        else $error("power readback upper byte wider than five bits");
    // The write edge, the ask register, the fire pulse and the word load take three edges in all.
    a_word_change_cause: assert property ($changed(tuning_word_ff)
        |-> $past(frame_retune) || $past(tune_ask, 3))
        else $error("active tuning word changed without an update");
    // The clear pulse is loaded on the same edge as the tuning word, so it shows three edges after the write.
    a_phase_pulse_cause: assert property (phase_clear_ff |-> $past(phase_ask, 3) ##1 !phase_clear_ff)
        else $error("phase clear pulse without a host request");
    a_guard_off_trip: assert property (guard_off |-> ##[1:2] !protect_trip_ff)
        else $error("trip stayed up after protection was switched off");
    a_trip_at_window: assert property ($rose(protect_trip_ff) |-> $past(smp_valid, 2))
        else $error("trip rose away from a window end");
    c_frame_update: cover property (frame_retune ##1 $changed(tuning_word_ff));
    c_trip_rise: cover property ($rose(protect_trip_ff));
    c_phase_pulse: cover property (phase_clear_ff);
endmodule // pgnco_regs_checker

bind pgnco_regs pgnco_regs_checker i_pgnco_regs_checker (.clk(clk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff), .smp_valid(smp_valid), .smp(smp),
    .frame_retune(frame_retune), .protect_trip_ff(protect_trip_ff), .tuning_word_ff(tuning_word_ff),
    .phase_clear_ff(phase_clear_ff));

/* pgnco_host_model.sv */
module pgnco_host_model
    import pgnco_pkg::*;
(
    input  wire logic         clk,
    output pgnco_reg_req_type reg_req,
    input  wire logic [7:0]   reg_rdata_ff,
    input  wire logic         reg_rvalid_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'hFF};
    // Released lines are inverted so that a stale address or data value cannot pass for a fresh one.
    task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        put(1'b1, a, d);
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        put(1'b0, a, 8'h00);
        for (int n = 0; n < 3 && reg_rvalid_ff !== 1'b1; n++) @(negedge clk);
        d = reg_rvalid_ff === 1'b1 ? reg_rdata_ff : 8'hXX;
    endtask
    // The request is dropped once done is seen or after eight reads; the task returns once done has fallen or after eight more reads.
    task automatic handshake(input logic [7:0] ask, input int done_bit, output logic ok);
        logic [7:0] d;
        d = 8'h00;
        write(8'h30, ask);
        for (int n = 0; n < 8 && d[done_bit] !== 1'b1; n++) read(8'h30, d);
        ok = d[done_bit];
        write(8'h30, 8'h00);
        for (int n = 0; n < 8 && d[done_bit] !== 1'b0; n++) read(8'h30, d);
        ok = ok && d[done_bit] === 1'b0;
    endtask
endmodule // pgnco_host_model

/* power_guard_and_nco_tuning_regs_test.sv */
module power_guard_and_nco_tuning_regs_test
    import pgnco_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               smp_valid = 1'b0;
    pgnco_iq_type       smp = '0;
    logic               frame_retune = 1'b0;
    pgnco_reg_req_type  reg_req;
    logic [7:0]         reg_rdata_ff;
    logic               reg_rvalid_ff;
    logic               protect_trip_ff;
    logic               phase_clear_ff;
    logic signed [31:0] tuning_word_ff;
    logic [7:0]         d;
    logic               ok;
    int                 bad_count = 0;
    int                 checks_done = 0;
    int                 pulses = 0;
    logic [7:0]         offs[11] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h2E};
    logic [7:0]         kept[11] = '{8'hFF, 8'h1F, 8'hCA, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};

    always #2 clk = ~clk;
    always @(posedge clk) if (phase_clear_ff === 1'b1) pulses++;

    pgnco_regs i_pgnco_regs (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .smp_valid(smp_valid), .smp(smp), .frame_retune(frame_retune),
        .protect_trip_ff(protect_trip_ff), .tuning_word_ff(tuning_word_ff), .phase_clear_ff(phase_clear_ff));
    pgnco_host_model i_pgnco_host_model (.clk(clk), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_pgnco_host_model.write(a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        i_pgnco_host_model.read(a, d);
        check({24'h0, d}, {24'h0, want});
    endtask
    task automatic load_word(input logic [31:0] w);
        for (int k = 0; k < 4; k++) wr(8'h31 + k[7:0], w[8*k +: 8]);
    endtask
    task automatic feed(input int n, input logic [15:0] ai, input logic [15:0] aq);
        @(negedge clk);
        smp <= '{i: ai, q: aq};
        smp_valid <= 1'b1;
        repeat (n) @(negedge clk);
        smp_valid <= 1'b0;
        smp <= '{i: ~ai, q: ~aq};
        repeat (4) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("Mismatches %0d of %0d checks", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // About 2000 cycles of traffic are expected; the limit leaves a wide margin.
    initial begin
        #80000;
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        foreach (offs[k]) rd(offs[k], offs[k] == 8'h34 ? 8'h10 : 8'h00);
        check(tuning_word_ff, 32'h0);
        foreach (offs[k]) if (k != 5) wr(offs[k], offs[k] == 8'h2B ? 8'hCA : 8'hFF);
        foreach (offs[k]) rd(offs[k], kept[k]);
        check(tuning_word_ff, 32'h0);
        wr(8'h2B, 8'h00);
        load_word(32'hF2345678);
        check(tuning_word_ff, 32'h0);
        i_pgnco_host_model.handshake(8'h01, 1, ok);
        check(ok, 1'b1);
        check(tuning_word_ff, 32'hF2345678);
        check(tuning_word_ff < 0, 1'b1);
        i_pgnco_host_model.handshake(8'h10, 5, ok);
        check(ok, 1'b1);
        check(pulses, 1);
        load_word(32'h0123ABCD);
        check(tuning_word_ff, 32'hF2345678);
        @(negedge clk);
        frame_retune <= 1'b1;
        @(negedge clk);
        frame_retune <= 1'b0;
        check(tuning_word_ff, 32'h0123ABCD);
        rd(8'h30, 8'h40);
        wr(8'h30, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h29, 8'h00);
        wr(8'h2A, 8'h04);
        wr(8'h2B, 8'h80);
        feed(512, 16'h4000, 16'h4000);
        check(protect_trip_ff, 1'b1);
        rd(8'h2C, 8'h00);
        rd(8'h2D, 8'h04);
        wr(8'h2B, 8'h00);
        @(negedge clk);
        check(protect_trip_ff, 1'b0);
        wr(8'h29, 8'h01);
        wr(8'h2B, 8'hC1);
        feed(512, 16'h0000, 16'h4000);
        rd(8'h2D, 8'h04);
        feed(512, 16'h0000, 16'h4000);
        rd(8'h2C, 8'h00);
        rd(8'h2D, 8'h02);
        check(protect_trip_ff, 1'b0);
        // A reset in mid-run must drop the active word even though the shadow bytes hold a value.
        arst_n = 1'b0;
        @(negedge clk);
        check(tuning_word_ff, 32'h0);
        arst_n = 1'b1;
        rd(8'h34, 8'h10);
        rd(8'h2B, 8'h00);
        complete_run();
    end
endmodule // power_guard_and_nco_tuning_regs_test
